// ### rtl/flag_and_move_exec.sv
// Flag set and clear, register copy and indirect fetch execution unit with an APB slave.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RQ1: Sign flag raise sets, drop clears it.
// RQ2: Overflow flag raise sets, drop clears it.
// RQ3: Transfer flag raise sets, drop clears it.
// RQ4: Half carry raise sets, drop clears it.
// RQ5: Pair copy moves source pair to destination.
// RQ6: Plain fetch via first pointer, pointer kept.
// RQ7: Post-increment fetch reads, then bumps first pointer.
// RQ8: Pre-decrement fetch lowers first pointer, then reads.
// RQ9: Pre-decrement fetch through second pointer likewise.
// RQ10: Pre-decrement fetch through third pointer likewise.
// RQ11: Flag ops touch one bit; moves keep flags.
module flag_and_move_exec
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // APB register slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data memory read port.
  output logic mem_req_q,
  output logic [15:0] mem_addr_q,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // Status outputs.
  output logic [7:0] flag_q,
  output logic busy_q
);
  import flag_move_pkg::*;

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  state_t state_q;                    // Execution sequencer state.
  logic [31:0] cmd_q;                 // Latched command word.
  logic [4:0] sel_q;                  // Register index for bus access.
  logic [REG_COUNT-1:0][7:0] regs_q;  // Register file contents.
  op_t cmd_op;                        // Decoded operation.
  mode_t cmd_mode;                    // Decoded addressing mode.
  logic [4:0] cmd_dst;                // Destination index.
  logic [4:0] cmd_src;                // Source index.
  logic [1:0] cmd_ptr;                // Pointer select.
  logic [3:0] ptr_pair;               // Register pair holding the selected pointer.
  logic [15:0] ptr_w;                 // Value of the selected pointer.
  logic [15:0] src_pair_w;            // Value of the source pair.
  logic [15:0] fetch_addr;            // Address of the fetch after any pre-decrement.
  logic is_flag_op;                   // Command is a flag set or clear.
  logic [7:0] flag_mask;              // Single bit that the flag command touches.
  logic setup_phase;                  // APB setup cycle.
  logic access_fire;                  // APB access completing at this edge.
  logic wr_fire;                      // Accepted write completing at this edge.
  logic byte_we;
  logic [4:0] byte_idx;
  logic [7:0] byte_data;
  logic pair_we;
  logic [15:0] pair_data;

  // ----------------------------------------------------------------
  // Command decode.
  // ----------------------------------------------------------------
  assign cmd_op = op_t'(cmd_q[CMD_OP_LSB +: 4]);
  assign cmd_mode = mode_t'(cmd_q[CMD_MODE_LSB +: 2]);
  assign cmd_dst = cmd_q[CMD_DST_LSB +: 5];
  assign cmd_src = cmd_q[CMD_SRC_LSB +: 5];
  assign cmd_ptr = cmd_q[CMD_PTR_LSB +: 2];
  assign src_pair_w = {regs_q[{cmd_src[4:1], 1'b1}], regs_q[{cmd_src[4:1], 1'b0}]};
  assign ptr_w = {regs_q[{ptr_pair, 1'b1}], regs_q[{ptr_pair, 1'b0}]};

  // Picks the pointer pair; the unused select code falls back to the first pointer.
  always_comb
  begin
    unique case (cmd_ptr)
      2'b01: ptr_pair = PTR_SECOND_PAIR;
      2'b10: ptr_pair = PTR_THIRD_PAIR;
      default: ptr_pair = PTR_FIRST_PAIR;
    endcase
  end

  // The pre-decrement form reads from the lowered pointer, the other forms from the pointer itself.
  assign fetch_addr = (cmd_mode == MODE_PRE_DEC) ? (ptr_w - PTR_STEP) : ptr_w; // [RQ8] [RQ9] [RQ10]

  // Builds the one-bit mask of a flag command, empty for every other command.
  always_comb
  begin
    flag_mask = 8'h00;
    is_flag_op = 1'b1;
    unique case (cmd_op)
      OP_RAISE_SIGN, OP_DROP_SIGN: flag_mask[FLAG_SIGN] = 1'b1;
      OP_RAISE_OVF, OP_DROP_OVF: flag_mask[FLAG_OVF] = 1'b1;
      OP_RAISE_XFER, OP_DROP_XFER: flag_mask[FLAG_XFER] = 1'b1;
      OP_RAISE_HALF, OP_DROP_HALF: flag_mask[FLAG_HALF] = 1'b1;
      default: is_flag_op = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign access_fire = psel && penable && pready;
  assign wr_fire = access_fire && pwrite && !pslverr;

  // Answers in the first access cycle; read data and error are settled during setup.
  // Writes other than to the select register are refused while a command runs.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
    end
    else if (setup_phase)
    begin
      pready <= 1'b1;
      prdata <= WORD_ZERO;
      pslverr <= 1'b0;
      unique case (paddr)
        OFF_CMD:
        begin
          pslverr <= !pwrite || busy_q;
        end
        OFF_STATUS:
        begin
          pslverr <= pwrite;
          prdata <= 32'(flag_q) | (32'(busy_q) << STAT_BUSY_BIT);
        end
        OFF_FLAGS:
        begin
          pslverr <= pwrite && busy_q;
          prdata <= 32'(flag_q);
        end
        OFF_REGSEL:
        begin
          prdata <= 32'(sel_q);
        end
        OFF_REGDATA:
        begin
          pslverr <= pwrite && busy_q;
          prdata <= 32'(regs_q[sel_q]);
        end
        default:
        begin
          pslverr <= 1'b1;
        end
      endcase
    end
    else if (access_fire)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Holds the register index that software selects for access.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_q <= 5'h00;
    end
    else if (wr_fire && (paddr == OFF_REGSEL))
    begin
      sel_q <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Execution sequencer.
  // ----------------------------------------------------------------
  // A command write starts one execute cycle; a fetch then waits for the memory answer.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      cmd_q <= WORD_ZERO;
      busy_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (wr_fire && (paddr == OFF_CMD))
          begin
            cmd_q <= pwdata;
            state_q <= ST_EXEC;
            busy_q <= 1'b1;
          end
        end
        ST_EXEC:
        begin
          if (cmd_op == OP_FETCH)
          begin
            state_q <= ST_WAIT;
          end
          else
          begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_WAIT:
        begin
          if (mem_ack)
          begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag word.
  // ----------------------------------------------------------------
  // A flag command changes only its own bit; software may rewrite the word only while idle.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_q <= FLAG_RST;
    end
    else if ((state_q == ST_EXEC) && is_flag_op)
    begin
      unique case (cmd_op)
        OP_RAISE_SIGN: flag_q[FLAG_SIGN] <= 1'b1; // [RQ1]
        OP_DROP_SIGN: flag_q[FLAG_SIGN] <= 1'b0; // [RQ1]
        OP_RAISE_OVF: flag_q[FLAG_OVF] <= 1'b1; // [RQ2]
        OP_DROP_OVF: flag_q[FLAG_OVF] <= 1'b0; // [RQ2]
        OP_RAISE_XFER: flag_q[FLAG_XFER] <= 1'b1; // [RQ3]
        OP_DROP_XFER: flag_q[FLAG_XFER] <= 1'b0; // [RQ3]
        OP_RAISE_HALF: flag_q[FLAG_HALF] <= 1'b1; // [RQ4]
        OP_DROP_HALF: flag_q[FLAG_HALF] <= 1'b0; // [RQ4] [RQ11]
        default: flag_q <= flag_q;
      endcase
    end
    else if (wr_fire && (paddr == OFF_FLAGS))
    begin
      flag_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Data memory port.
  // ----------------------------------------------------------------
  // The request rises at the edge that ends the execute cycle of a fetch and stands until the memory acknowledges.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_req_q <= 1'b0;
      mem_addr_q <= 16'h0000;
    end
    else if ((state_q == ST_EXEC) && (cmd_op == OP_FETCH))
    begin
      mem_req_q <= 1'b1;
      mem_addr_q <= fetch_addr; // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10]
    end
    else if ((state_q == ST_WAIT) && mem_ack)
    begin
      mem_req_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file write steering.
  // ----------------------------------------------------------------
  // The byte port serves fetch results, single copies and idle bus writes, which never overlap.
  always_comb
  begin
    byte_we = 1'b0;
    byte_idx = sel_q;
    byte_data = pwdata[7:0];
    if ((state_q == ST_WAIT) && mem_ack)
    begin
      byte_we = 1'b1; // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10]
      byte_idx = cmd_dst;
      byte_data = mem_rdata;
    end
    else if ((state_q == ST_EXEC) && (cmd_op == OP_REG_COPY))
    begin
      byte_we = 1'b1;
      byte_idx = cmd_dst;
      byte_data = regs_q[cmd_src];
    end
    else if (wr_fire && (paddr == OFF_REGDATA))
    begin
      byte_we = 1'b1;
    end
  end

  // The pair port serves pair copies and pointer updates; a plain fetch leaves the pointer alone.
  always_comb
  begin
    pair_we = 1'b0;
    pair_data = src_pair_w;
    if ((state_q == ST_EXEC) && (cmd_op == OP_PAIR_COPY))
    begin
      pair_we = 1'b1; // [RQ5]
    end
    else if ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_POST_INC))
    begin
      pair_we = 1'b1;
      pair_data = ptr_w + PTR_STEP; // [RQ7]
    end
    else if ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_PRE_DEC))
    begin
      pair_we = 1'b1;
      pair_data = fetch_addr; // [RQ8] [RQ9] [RQ10]
    end
  end

  // Register file instance.
  pair_regfile u_regs
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .byte_we(byte_we),
    .byte_idx(byte_idx),
    .byte_data(byte_data),
    .pair_we(pair_we),
    .pair_idx((cmd_op == OP_PAIR_COPY) ? cmd_dst[4:1] : ptr_pair),
    .pair_data(pair_data),
    .regs_q(regs_q)
  );

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_sign_raise: // [RQ1]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_RAISE_SIGN) |=> flag_q[FLAG_SIGN])
    else $error("Sign flag not raised.");
  chk_sign_drop: // [RQ1]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_DROP_SIGN) |=> !flag_q[FLAG_SIGN])
    else $error("Sign flag not dropped.");
  chk_ovf_raise: // [RQ2]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_RAISE_OVF) |=> flag_q[FLAG_OVF])
    else $error("Overflow flag not raised.");
  chk_ovf_drop: // [RQ2]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_DROP_OVF) |=> !flag_q[FLAG_OVF])
    else $error("Overflow flag not dropped.");
  chk_xfer_flag_ops: // [RQ3]
    assert property ((state_q == ST_EXEC) && (cmd_op inside {OP_RAISE_XFER, OP_DROP_XFER})
                     |=> flag_q[FLAG_XFER] == $past(cmd_q[CMD_OP_LSB]))
    else $error("Transfer flag wrong after its command.");
  chk_half_flag_ops: // [RQ4]
    assert property ((state_q == ST_EXEC) && (cmd_op inside {OP_RAISE_HALF, OP_DROP_HALF})
                     |=> flag_q[FLAG_HALF] == $past(cmd_q[CMD_OP_LSB]))
    else $error("Half carry flag wrong after its command.");
  chk_pair_copy_value: // [RQ5]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_PAIR_COPY)
                     |=> {regs_q[{cmd_dst[4:1], 1'b1}], regs_q[{cmd_dst[4:1], 1'b0}]} == $past(src_pair_w))
    else $error("Pair copy result wrong.");
  chk_plain_fetch_ptr: // [RQ6]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_PLAIN)
                     |=> mem_req_q && (mem_addr_q == $past(ptr_w)) && $stable(ptr_w))
    else $error("Plain fetch address or pointer wrong.");
  chk_post_inc_ptr: // [RQ7]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_POST_INC)
                     |=> (mem_addr_q == $past(ptr_w)) && (ptr_w == mem_addr_q + PTR_STEP))
    else $error("Post-increment fetch wrong.");
  chk_pre_dec_first: // [RQ8]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_PRE_DEC)
                     && (ptr_pair == PTR_FIRST_PAIR) |=> (mem_addr_q == $past(ptr_w) - PTR_STEP) && (ptr_w == mem_addr_q))
    else $error("Pre-decrement fetch via first pointer wrong.");
  chk_pre_dec_second: // [RQ9]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_PRE_DEC)
                     && (ptr_pair == PTR_SECOND_PAIR) |=> (mem_addr_q == $past(ptr_w) - PTR_STEP) && (ptr_w == mem_addr_q))
    else $error("Pre-decrement fetch via second pointer wrong.");
  chk_pre_dec_third: // [RQ10]
    assert property ((state_q == ST_EXEC) && (cmd_op == OP_FETCH) && (cmd_mode == MODE_PRE_DEC)
                     && (ptr_pair == PTR_THIRD_PAIR) |=> (mem_addr_q == $past(ptr_w) - PTR_STEP) && (ptr_w == mem_addr_q))
    else $error("Pre-decrement fetch via third pointer wrong.");
  chk_fetch_load_dest: // [RQ6]
    assert property ((state_q == ST_WAIT) && mem_ack |=> (regs_q[cmd_dst] == $past(mem_rdata)) && !mem_req_q && !busy_q)
    else $error("Fetched byte not loaded.");
  chk_flag_one_bit: // [RQ11]
    assert property ((state_q == ST_EXEC) && is_flag_op |=> ((flag_q ^ $past(flag_q)) & ~$past(flag_mask)) == 8'h00)
    else $error("Flag command touched another bit.");
  chk_move_keeps_flags: // [RQ11]
    assert property ((state_q != ST_IDLE) && !is_flag_op |=> $stable(flag_q))
    else $error("Copy or fetch changed the flags.");

endmodule
`default_nettype wire

// ### rtl/flag_move_pkg.sv
// Constants, field layouts and state encodings shared by the flag and move execution unit.
package flag_move_pkg;

  // ----------------------------------------------------------------
  // Register bus map (byte addresses on the 12-bit APB address).
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CMD = 12'h000;     // Command issue, write only.
  localparam logic [11:0] OFF_STATUS = 12'h004;  // Busy bit and flag word, read only.
  localparam logic [11:0] OFF_FLAGS = 12'h008;   // Flag word, read and write.
  localparam logic [11:0] OFF_REGSEL = 12'h00C;  // Register file index, read and write.
  localparam logic [11:0] OFF_REGDATA = 12'h010; // Selected register contents, read and write.

  // ----------------------------------------------------------------
  // Command word layout.
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;     // Four-bit operation code.
  localparam int CMD_DST_LSB = 4;    // Five-bit destination register index.
  localparam int CMD_SRC_LSB = 9;    // Five-bit source register index.
  localparam int CMD_PTR_LSB = 14;   // Two-bit pointer select.
  localparam int CMD_MODE_LSB = 16;  // Two-bit addressing mode.
  localparam int STAT_BUSY_BIT = 8;  // Busy flag position in the status word.

  // ----------------------------------------------------------------
  // Flag word layout and reset values.
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_OVF = 3'h3;   // Two's-complement overflow flag.
  localparam logic [2:0] FLAG_SIGN = 3'h4;  // Sign flag.
  localparam logic [2:0] FLAG_HALF = 3'h5;  // Half carry flag.
  localparam logic [2:0] FLAG_XFER = 3'h6;  // Bit-transfer flag.
  localparam logic [7:0] FLAG_RST = 8'h00;  // Flag word after reset.
  localparam logic [7:0] REG_RST = 8'h00;   // Register file entries after reset.
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register file geometry and pointer pairs.
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 32;              // Number of byte registers.
  localparam logic [3:0] PTR_FIRST_PAIR = 4'hD;   // Registers 26 and 27.
  localparam logic [3:0] PTR_SECOND_PAIR = 4'hE;  // Registers 28 and 29.
  localparam logic [3:0] PTR_THIRD_PAIR = 4'hF;   // Registers 30 and 31.
  localparam logic [15:0] PTR_STEP = 16'h0001;    // Pointer increment and decrement step.

  // Operation codes carried in the command word.
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_RAISE_SIGN = 4'b0001,
    OP_DROP_SIGN = 4'b0010,
    OP_RAISE_OVF = 4'b0011,
    OP_DROP_OVF = 4'b0100,
    OP_RAISE_XFER = 4'b0101,
    OP_DROP_XFER = 4'b0110,
    OP_RAISE_HALF = 4'b0111,
    OP_DROP_HALF = 4'b1000,
    OP_REG_COPY = 4'b1001,
    OP_PAIR_COPY = 4'b1010,
    OP_FETCH = 4'b1011
  } op_t;

  // Addressing modes of the indirect fetch.
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_POST_INC = 2'b01,
    MODE_PRE_DEC = 2'b10
  } mode_t;

  // Execution sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } state_t;

endpackage

// ### rtl/pair_regfile.sv
// Thirty-two entry byte register file with a byte write port and a pair write port.
`timescale 1ns/1ns
`default_nettype none
module pair_regfile
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Byte write port, wins over the pair port on the same entry.
  input wire logic byte_we,
  input wire logic [4:0] byte_idx,
  input wire logic [7:0] byte_data,
  // Pair write port, low byte to the even entry.
  input wire logic pair_we,
  input wire logic [3:0] pair_idx,
  input wire logic [15:0] pair_data,
  // All entries, straight from their flip-flops.
  output logic [flag_move_pkg::REG_COUNT-1:0][7:0] regs_q
);
  import flag_move_pkg::*;

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------
  // Each entry loads from the byte port when addressed there, otherwise from its half of the pair port.
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_entry
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        regs_q[i] <= REG_RST;
      end
      else if (byte_we && (byte_idx == 5'(i)))
      begin
        regs_q[i] <= byte_data;
      end
      else if (pair_we && (pair_idx == 4'(i / 2)))
      begin
        regs_q[i] <= pair_data[(i % 2) * 8 +: 8];
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the flag and move execution unit.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import flag_move_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, response and bookkeeping.
  // ----------------------------------------------------------------
  logic clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_req_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_rdata;
  logic mem_ack;
  logic [7:0] flag_q;
  logic busy_q;
  int error_cnt;
  int n_compared;
  logic [31:0] rd; // Read data taken at the completing edge.
  logic err; // Error response taken at the completing edge.
  op_t raise_ops[4] = '{OP_RAISE_SIGN, OP_RAISE_OVF, OP_RAISE_XFER, OP_RAISE_HALF};
  op_t drop_ops[4] = '{OP_DROP_SIGN, OP_DROP_OVF, OP_DROP_XFER, OP_DROP_HALF};
  logic [2:0] flag_pos[4] = '{FLAG_SIGN, FLAG_OVF, FLAG_XFER, FLAG_HALF};

  // The unit under test.
  flag_and_move_exec dut
  (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .flag_q(flag_q), .busy_q(busy_q)
  );

  // Free-running core clock, 100 ns period.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch and ends the run.
  task automatic timeout(input string what);
    error_cnt++;
    $display("mismatch at %0t: no %s in time", $time, what);
    complete_run();
  endtask

  // One APB transfer; waits an edge first so back-to-back calls never drive psel twice in one step.
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
      timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register file access goes through the index and data registers.
  task automatic set_reg(input logic [4:0] idx, input logic [7:0] val);
    apb_xfer(1'b1, OFF_REGSEL, 32'(idx));
    apb_xfer(1'b1, OFF_REGDATA, 32'(val));
  endtask

  task automatic get_reg(input logic [4:0] idx);
    apb_xfer(1'b1, OFF_REGSEL, 32'(idx));
    apb_xfer(1'b0, OFF_REGDATA, WORD_ZERO);
  endtask

  // Waits for the busy flag to drop, under a bound.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (i > 0 && busy_q === 1'b0)
        break;
    end
    if (i == 40)
      timeout("completion");
  endtask

  // Builds a command word from its fields.
  function automatic logic [31:0] mk_cmd(op_t op, logic [4:0] dst, logic [4:0] src, logic [1:0] ptr, mode_t mode);
    return (32'(op) << CMD_OP_LSB) | (32'(dst) << CMD_DST_LSB) | (32'(src) << CMD_SRC_LSB)
      | (32'(ptr) << CMD_PTR_LSB) | (32'(mode) << CMD_MODE_LSB);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  // Each flag is raised from all-clear and dropped from all-set, so a stray bit shows.
  task automatic test_flags();
    int k;
    for (k = 0; k < 4; k++)
    begin
      apb_xfer(1'b1, OFF_FLAGS, WORD_ZERO);
      apb_xfer(1'b1, OFF_CMD, mk_cmd(raise_ops[k], 5'h00, 5'h00, 2'h0, MODE_PLAIN));
      wait_idle();
      check(32'(flag_q), 32'h0000_0001 << flag_pos[k]);
      apb_xfer(1'b1, OFF_FLAGS, 32'h0000_00FF);
      apb_xfer(1'b1, OFF_CMD, mk_cmd(drop_ops[k], 5'h00, 5'h00, 2'h0, MODE_PLAIN));
      wait_idle();
      apb_xfer(1'b0, OFF_STATUS, WORD_ZERO);
      check(rd, 32'h0000_00FF & ~(32'h0000_0001 << flag_pos[k]));
    end
  endtask

  // Pair copy into a pair that held other data, then a single copy; flags must survive.
  task automatic test_pair_copy();
    apb_xfer(1'b1, OFF_FLAGS, 32'h0000_00A5);
    set_reg(5'h04, 8'h3C);
    set_reg(5'h05, 8'hC3);
    set_reg(5'h0B, 8'h11);
    apb_xfer(1'b1, OFF_CMD, mk_cmd(OP_PAIR_COPY, 5'h0A, 5'h04, 2'h0, MODE_PLAIN));
    wait_idle();
    // A single copy takes the odd source byte into an unrelated register.
    apb_xfer(1'b1, OFF_CMD, mk_cmd(OP_REG_COPY, 5'h0C, 5'h05, 2'h0, MODE_PLAIN));
    wait_idle();
    get_reg(5'h0C);
    check(rd, 32'h0000_00C3);
    get_reg(5'h0A);
    check(rd, 32'h0000_003C);
    get_reg(5'h0B);
    check(rd, 32'h0000_00C3);
    check(32'(flag_q), 32'h0000_00A5);
  endtask

  // One fetch: checks the address, answers after an optional stall, then checks dest and pointer.
  task automatic fetch_case(input logic [1:0] ptr, input mode_t mode, input logic [15:0] start,
                            input logic [15:0] exp_addr, input logic [15:0] exp_ptr, input logic [7:0] data,
                            input logic stall);
    int i;
    logic [7:0] lo_b;
    set_reg(5'(26 + 2 * ptr), start[7:0]);
    set_reg(5'(27 + 2 * ptr), start[15:8]);
    apb_xfer(1'b1, OFF_CMD, mk_cmd(OP_FETCH, 5'h03, 5'h00, ptr, mode));
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (mem_req_q === 1'b1)
        break;
    end
    if (i == 20)
      timeout("memory request");
    check(32'(mem_addr_q), 32'(exp_addr));
    // A slow memory lets software try a flag write, which must be refused while busy.
    if (stall)
    begin
      apb_xfer(1'b1, OFF_FLAGS, WORD_ZERO);
      check(32'(err), 32'h0000_0001);
      // The status word shows the busy bit beside the untouched flags while the fetch waits.
      apb_xfer(1'b0, OFF_STATUS, WORD_ZERO);
      check(rd, (32'h0000_0001 << STAT_BUSY_BIT) | 32'h0000_00A5);
      check(32'(mem_addr_q), 32'(exp_addr));
    end
    mem_ack <= 1'b1;
    mem_rdata <= data;
    @(posedge clk);
    mem_ack <= 1'b0;
    mem_rdata <= ~data;
    wait_idle();
    get_reg(5'h03);
    check(rd, 32'(data));
    get_reg(5'(26 + 2 * ptr));
    lo_b = rd[7:0];
    get_reg(5'(27 + 2 * ptr));
    check({16'h0000, rd[7:0], lo_b}, 32'(exp_ptr));
    check(32'(flag_q), 32'h0000_00A5);
  endtask

  // Unmapped address, read of the command word and write of the status word are refused.
  task automatic test_refusals();
    apb_xfer(1'b0, 12'h020, WORD_ZERO);
    check(32'(err), 32'h0000_0001);
    apb_xfer(1'b0, OFF_CMD, WORD_ZERO);
    check(32'(err), 32'h0000_0001);
    apb_xfer(1'b1, OFF_STATUS, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(32'(flag_q), 32'h0000_00A5);
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = WORD_ZERO;
    mem_rdata = 8'hA5;
    mem_ack = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check({22'h00_0000, busy_q, mem_req_q, flag_q}, WORD_ZERO);
    test_flags();
    test_pair_copy();
    fetch_case(2'h0, MODE_PLAIN, 16'h1234, 16'h1234, 16'h1234, 8'h5E, 1'b0);
    // The spare mode code behaves as a plain fetch.
    fetch_case(2'h0, mode_t'(2'h3), 16'h4321, 16'h4321, 16'h4321, 8'hA6, 1'b0);
    fetch_case(2'h0, MODE_POST_INC, 16'h12FF, 16'h12FF, 16'h1300, 8'h61, 1'b1);
    fetch_case(2'h0, MODE_PRE_DEC, 16'h1300, 16'h12FF, 16'h12FF, 8'h72, 1'b0);
    fetch_case(2'h1, MODE_PRE_DEC, 16'h0200, 16'h01FF, 16'h01FF, 8'h83, 1'b1);
    fetch_case(2'h2, MODE_PRE_DEC, 16'h0000, 16'hFFFF, 16'hFFFF, 8'h94, 1'b1);
    test_refusals();
    complete_run();
  end
endmodule
`default_nettype wire
